//--- src/lpc_pkg.sv
/*
  Shared constants of the low-power calibration sequencer and trim bank.
  Assumes a single 200 MHz converter clock and 32-bit Avalon-MM access.
*/
// Operation
// - control register resets to 0x88
// - sleep codes 0-3 select short sleep counts
// - sleep codes 4-7 select long counts, 4 default
// - sleep count used only enabled, autonomous mode
// - settle wait after wake, only when enabled
// - settle codes 0-3 select counts, 1 default
// - trigger mode clear: timed autonomous wake
// - trigger mode set: sleep while trigger high
// - enable bit gated by background calibration mode
// - gain trim adjusts all cores
// - reference trim in bits 3:0, rest reserved
// - three per-input termination trims
// - trims reset to fuse values, rewritable
// - trigger from pin or software per source bit
// - software trigger bit resets to one
package lpc_pkg;
  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] LPC_IDX_MODE   = 8'h6A;
  localparam logic [7:0] LPC_IDX_SOFT   = 8'h6C;
  localparam logic [7:0] LPC_IDX_CTRL   = 8'h6E;
  localparam logic [7:0] LPC_IDX_STAT   = 8'h6F;
  localparam logic [7:0] LPC_IDX_GAIN   = 8'h7A;
  localparam logic [7:0] LPC_IDX_REF    = 8'h7C;
  localparam logic [7:0] LPC_IDX_TERM0  = 8'h7E;
  localparam logic [7:0] LPC_IDX_TERM1  = 8'h7F;
  localparam logic [7:0] LPC_IDX_TERM2  = 8'h80;
  // ==========================================================
  // field positions and reset values
  localparam int         LPC_EN_BIT     = 0;
  localparam int         LPC_TRIG_BIT   = 1;
  localparam int         LPC_SRC_BIT    = 1;
  localparam logic [7:0] LPC_CTRL_RST   = 8'h88;
  localparam logic [7:0] LPC_CTRL_MASK  = 8'hFB;
  localparam logic       LPC_SOFT_RST   = 1'b1;
  localparam logic [1:0] LPC_MODE_RST   = 2'h0;
  localparam int         LPC_CORES      = 5;
  localparam int         LPC_CNT_W      = 41;
  // ==========================================================
  // interval lengths in converter clock periods
  localparam logic [7:0][40:0] LPC_SLEEP_CYC = {
    41'd1099511627904, 41'd137438953600, 41'd17179869312, 41'd2147483776,
    41'd268435584, 41'd33554560, 41'd4194432, 41'd1152};
  localparam logic [3:0][40:0] LPC_WAKE_CYC = {
    41'd2147483776, 41'd268435584, 41'd33554560, 41'd1152};
  typedef enum logic [1:0] {LPC_IDLE, LPC_SLEEP, LPC_SETTLE, LPC_CALIB} lpc_state_t;
endpackage : lpc_pkg

//--- src/lpc_tmr_if.sv
/*
  Start, length and expiry of one interval, sequencer to timer.
  Assumes both ends on the converter clock.
*/
interface lpc_tmr_if;
  import lpc_pkg::*;
  logic                 start;
  logic [LPC_CNT_W-1:0] limit;
  logic                 done;
  modport ctrl  (output start, output limit, input done);
  modport timer (input start, input limit, output done);
endinterface : lpc_tmr_if

//--- src/lpc_sync2.sv
/*
  Two-flop synchroniser for a level from outside the clock domain.
  Assumes the level is slow against the clock.
*/
module lpc_sync2 (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta_reg <= 1'b0;
      q_out    <= 1'b0;
    end else begin
      meta_reg <= d_in;
      q_out    <= meta_reg;
    end
  end
endmodule : lpc_sync2

//--- src/lpc_interval_timer.sv
/*
  Wide up-counter timing one sleep or settle interval.
  Assumes limit is at least one and start is a one-cycle pulse.
*/
module lpc_interval_timer
  import lpc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  lpc_tmr_if.timer  tmr
);
  logic [LPC_CNT_W-1:0] cnt_reg;
  logic [LPC_CNT_W-1:0] lim_reg;
  logic                 run_reg;
  logic                 done_reg;
  assign tmr.done = done_reg;
  // restart on every start pulse, done pulses limit cycles later
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= '0;
      lim_reg  <= '0;
      run_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (tmr.start) begin
        cnt_reg <= '0;
        lim_reg <= tmr.limit - 41'd1;
        run_reg <= 1'b1;
      end else if (run_reg) begin
        if (cnt_reg == lim_reg) begin
          run_reg  <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 41'd1;
        end
      end
    end
  end
endmodule : lpc_interval_timer

//--- src/lpc_top.sv
/*
  Low-power background calibration sequencer with its control
  registers and the factory trim registers, on an Avalon-MM slave.
  Assumes fuse values are static and on this clock, the trigger pin
  is asynchronous, and the calibration engine answers on this clock.
*/
// Chosen here: the Avalon-MM slave port.
module lpc_top
  import lpc_pkg::*;
#(
  parameter logic [7:0][40:0] SLEEP_CYC = LPC_SLEEP_CYC,
  parameter logic [3:0][40:0] WAKE_CYC  = LPC_WAKE_CYC
) (
  input  wire logic       CLK_IN,
  input  wire logic       RST_IN,
  input  wire logic [9:0] AVS_ADDRESS_IN,
  input  wire logic       AVS_READ_IN,
  input  wire logic       AVS_WRITE_IN,
  input  wire logic [31:0] AVS_WRITEDATA_IN,
  input  wire logic [3:0] AVS_BYTEENABLE_IN,
  output logic [31:0]     AVS_READDATA_OUT,
  output logic            AVS_WAITREQUEST_OUT,
  input  wire logic       CAL_TRIGGER_PIN_IN,
  input  wire logic       CAL_DONE_IN,
  input  wire logic [7:0] FUSE_GAIN_IN,
  input  wire logic [3:0] FUSE_REF_IN,
  input  wire logic [7:0] FUSE_TERM0_IN,
  input  wire logic [7:0] FUSE_TERM1_IN,
  input  wire logic [7:0] FUSE_TERM2_IN,
  output logic            CORE_SLEEP_OUT,
  output logic            CAL_START_OUT,
  output logic [2:0]      OFFLINE_CORE_OUT,
  output logic [7:0]      GAIN_ADJ_OUT,
  output logic [3:0]      REF_ADJ_OUT,
  output logic [7:0]      TERM_ADJ0_OUT,
  output logic [7:0]      TERM_ADJ1_OUT,
  output logic [7:0]      TERM_ADJ2_OUT
);
  // ==========================================================
  // registers and shared signals
  logic [7:0]  lowpower_calibration_control_reg;
  logic [1:0]  mode_reg;
  logic        software_cal_trigger_bit_reg;
  lpc_state_t  state_reg;
  logic        pin_sync;
  logic        trig;
  logic        lp_active;
  logic        req;
  logic        wr_go;
  logic [7:0]  idx;
  logic [7:0]  rd_next;
  logic [2:0]  sleep_interval_code;
  logic [1:0]  settle_interval_code;
  logic        sleep_by_trigger_select;
  logic        lowpower_cal_enable;
  logic        background_calibration_mode;
  logic        trigger_source_select;
  lpc_tmr_if   tmr ();

  lpc_sync2 u_sync (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .d_in   (CAL_TRIGGER_PIN_IN),
    .q_out  (pin_sync)
  );

  lpc_interval_timer u_timer (
    .clk_in (CLK_IN),
    .rst_in (RST_IN),
    .tmr    (tmr)
  );

  assign sleep_interval_code         = lowpower_calibration_control_reg[7:5];
  assign settle_interval_code        = lowpower_calibration_control_reg[4:3];
  assign sleep_by_trigger_select     = lowpower_calibration_control_reg[LPC_TRIG_BIT];
  assign lowpower_cal_enable         = lowpower_calibration_control_reg[LPC_EN_BIT];
  assign background_calibration_mode = mode_reg[0];
  assign trigger_source_select       = mode_reg[LPC_SRC_BIT];
  // the pin is ignored entirely while software owns the trigger
  assign trig      = trigger_source_select ? pin_sync
                                           : software_cal_trigger_bit_reg;
  assign lp_active = lowpower_cal_enable & background_calibration_mode;

  // ==========================================================
  // Avalon-MM slave: one wait cycle, then the access completes
  assign req   = AVS_READ_IN | AVS_WRITE_IN;
  assign idx   = AVS_ADDRESS_IN[9:2];
  assign wr_go = AVS_WRITE_IN & ~AVS_WAITREQUEST_OUT & AVS_BYTEENABLE_IN[0]
               & (AVS_ADDRESS_IN[1:0] == 2'h0);

  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end else if (req && AVS_WAITREQUEST_OUT) begin
      AVS_WAITREQUEST_OUT <= 1'b0;
    end else begin
      AVS_WAITREQUEST_OUT <= 1'b1;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    if (AVS_ADDRESS_IN[1:0] == 2'h0) begin
      case (idx)
        LPC_IDX_MODE:  rd_next = {6'h00, mode_reg};
        LPC_IDX_SOFT:  rd_next = {7'h00, software_cal_trigger_bit_reg};
        LPC_IDX_CTRL:  rd_next = lowpower_calibration_control_reg;
        LPC_IDX_STAT:  rd_next = {2'h0, trig, OFFLINE_CORE_OUT, state_reg};
        LPC_IDX_GAIN:  rd_next = GAIN_ADJ_OUT;
        LPC_IDX_REF:   rd_next = {4'h0, REF_ADJ_OUT};
        LPC_IDX_TERM0: rd_next = TERM_ADJ0_OUT;
        LPC_IDX_TERM1: rd_next = TERM_ADJ1_OUT;
        LPC_IDX_TERM2: rd_next = TERM_ADJ2_OUT;
        default:       rd_next = 8'h00;
      endcase
    end
  end

  // read data captured in the wait cycle, so it stands at completion
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      AVS_READDATA_OUT <= 32'h0;
    end else if (AVS_READ_IN && AVS_WAITREQUEST_OUT) begin
      AVS_READDATA_OUT <= {24'h0, rd_next};
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      lowpower_calibration_control_reg <= LPC_CTRL_RST;
      software_cal_trigger_bit_reg     <= LPC_SOFT_RST;
      mode_reg                         <= LPC_MODE_RST;
    end else if (wr_go) begin
      case (idx)
        // reserved bit 2 is not stored and reads zero
        LPC_IDX_CTRL: lowpower_calibration_control_reg <= AVS_WRITEDATA_IN[7:0] & LPC_CTRL_MASK;
        LPC_IDX_SOFT: software_cal_trigger_bit_reg     <= AVS_WRITEDATA_IN[0];
        LPC_IDX_MODE: mode_reg                         <= AVS_WRITEDATA_IN[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // trim registers: fuse values at reset, software may overwrite
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      GAIN_ADJ_OUT  <= FUSE_GAIN_IN;
      REF_ADJ_OUT   <= FUSE_REF_IN;
      TERM_ADJ0_OUT <= FUSE_TERM0_IN;
      TERM_ADJ1_OUT <= FUSE_TERM1_IN;
      TERM_ADJ2_OUT <= FUSE_TERM2_IN;
    end else if (wr_go) begin
      case (idx)
        LPC_IDX_GAIN:  GAIN_ADJ_OUT  <= AVS_WRITEDATA_IN[7:0];
        LPC_IDX_REF:   REF_ADJ_OUT   <= AVS_WRITEDATA_IN[3:0];
        LPC_IDX_TERM0: TERM_ADJ0_OUT <= AVS_WRITEDATA_IN[7:0];
        LPC_IDX_TERM1: TERM_ADJ1_OUT <= AVS_WRITEDATA_IN[7:0];
        LPC_IDX_TERM2: TERM_ADJ2_OUT <= AVS_WRITEDATA_IN[7:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // low-power sequence: sleep, settle, calibrate, next core
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      state_reg        <= LPC_IDLE;
      tmr.start        <= 1'b0;
      tmr.limit        <= '0;
      CORE_SLEEP_OUT   <= 1'b0;
      CAL_START_OUT    <= 1'b0;
      OFFLINE_CORE_OUT <= 3'h0;
    end else begin
      tmr.start <= 1'b0;
      if (!lp_active) begin
        // leaving low-power mode wakes the core and drops any request
        state_reg      <= LPC_IDLE;
        CORE_SLEEP_OUT <= 1'b0;
        CAL_START_OUT  <= 1'b0;
      end else begin
        case (state_reg)
          LPC_IDLE: begin
            state_reg      <= LPC_SLEEP;
            CORE_SLEEP_OUT <= 1'b1;
            tmr.start      <= 1'b1;
            tmr.limit      <= SLEEP_CYC[sleep_interval_code];
          end
          LPC_SLEEP: begin
            if (sleep_by_trigger_select ? !trig : tmr.done) begin
              state_reg      <= LPC_SETTLE;
              CORE_SLEEP_OUT <= 1'b0;
              tmr.start      <= 1'b1;
              tmr.limit      <= WAKE_CYC[settle_interval_code];
            end
          end
          LPC_SETTLE: begin
            if (tmr.done) begin
              state_reg     <= LPC_CALIB;
              CAL_START_OUT <= 1'b1;
            end
          end
          LPC_CALIB: begin
            if (CAL_DONE_IN) begin
              state_reg        <= LPC_SLEEP;
              CAL_START_OUT    <= 1'b0;
              CORE_SLEEP_OUT   <= 1'b1;
              tmr.start        <= 1'b1;
              tmr.limit        <= SLEEP_CYC[sleep_interval_code];
              OFFLINE_CORE_OUT <= (OFFLINE_CORE_OUT == 3'(LPC_CORES - 1)) ? 3'h0
                                : OFFLINE_CORE_OUT + 3'h1;
            end
          end
          default: state_reg <= LPC_IDLE;
        endcase
      end
    end
  end

  // ==========================================================
  // assertions
  a_ctrl_reset: assert property (@(posedge CLK_IN) $past(RST_IN) && RST_IN
    |=> lowpower_calibration_control_reg == 8'h88) else $error("ctrl reset");
  a_soft_reset: assert property (@(posedge CLK_IN) RST_IN
    |=> software_cal_trigger_bit_reg) else $error("soft trigger reset");
  a_idle_off: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !lp_active |=> state_reg == LPC_IDLE && !CORE_SLEEP_OUT) else $error("not idle");
  a_trig_wake: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == LPC_SLEEP && lp_active && sleep_by_trigger_select && !trig
    |=> state_reg == LPC_SETTLE && tmr.start) else $error("no trigger wake");
  a_trig_hold: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == LPC_SLEEP && lp_active && sleep_by_trigger_select && trig
    |=> CORE_SLEEP_OUT) else $error("woke with trigger high");
  a_auto_sleep: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == LPC_SLEEP && lp_active && !sleep_by_trigger_select && !tmr.done
    |=> state_reg == LPC_SLEEP) else $error("early wake");
  a_settle_cal: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == LPC_SETTLE && lp_active && tmr.done
    |=> CAL_START_OUT ##0 $past(!CAL_START_OUT)) else $error("no cal start");
  a_sleep_len: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    state_reg == LPC_IDLE && lp_active
    |=> tmr.limit == SLEEP_CYC[$past(sleep_interval_code)]) else $error("sleep len");
  a_bus_wait: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    req && AVS_WAITREQUEST_OUT |=> !AVS_WAITREQUEST_OUT ##1 AVS_WAITREQUEST_OUT)
    else $error("bus answer");
  a_src_soft: assert property (@(posedge CLK_IN) disable iff (RST_IN)
    !trigger_source_select |-> trig == software_cal_trigger_bit_reg)
    else $error("pin not ignored");
endmodule : lpc_top

//--- sim/test_lowpower_cal_sleep_wake_and_trims.sv
/*
  Self-checking bench for lpc_top: registers, trims, sleep and settle timing.
  Assumes lpc_pkg is compiled first and the design answers as its note states.
*/
module test_lowpower_cal_sleep_wake_and_trims
  import lpc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // short intervals keep the run small; codes stay 8 cycles apart
  localparam logic [7:0][40:0] T_SLEEP = {41'd72, 41'd64, 41'd56, 41'd48,
                                          41'd40, 41'd32, 41'd24, 41'd16};
  localparam logic [3:0][40:0] T_WAKE  = {41'd40, 41'd32, 41'd24, 41'd16};
  logic        CLK_IN, RST_IN, AVS_READ_IN, AVS_WRITE_IN, CAL_TRIGGER_PIN_IN, CAL_DONE_IN;
  logic [9:0]  AVS_ADDRESS_IN;
  logic [31:0] AVS_WRITEDATA_IN, AVS_READDATA_OUT, rd;
  logic [3:0]  AVS_BYTEENABLE_IN, FUSE_REF_IN, REF_ADJ_OUT;
  logic        AVS_WAITREQUEST_OUT, CORE_SLEEP_OUT, CAL_START_OUT;
  logic [2:0]  OFFLINE_CORE_OUT, core;
  logic [7:0]  FUSE_GAIN_IN, FUSE_TERM0_IN, FUSE_TERM1_IN, FUSE_TERM2_IN, v;
  logic [7:0]  GAIN_ADJ_OUT, TERM_ADJ0_OUT, TERM_ADJ1_OUT, TERM_ADJ2_OUT;
  int          miscompares, checks, n, d, seed;
  lpc_top #(.SLEEP_CYC(T_SLEEP), .WAKE_CYC(T_WAKE)) i_dut (
    .CLK_IN              (CLK_IN),
    .RST_IN              (RST_IN),
    .AVS_ADDRESS_IN      (AVS_ADDRESS_IN),
    .AVS_READ_IN         (AVS_READ_IN),
    .AVS_WRITE_IN        (AVS_WRITE_IN),
    .AVS_WRITEDATA_IN    (AVS_WRITEDATA_IN),
    .AVS_BYTEENABLE_IN   (AVS_BYTEENABLE_IN),
    .AVS_READDATA_OUT    (AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT (AVS_WAITREQUEST_OUT),
    .CAL_TRIGGER_PIN_IN  (CAL_TRIGGER_PIN_IN),
    .CAL_DONE_IN         (CAL_DONE_IN),
    .FUSE_GAIN_IN        (FUSE_GAIN_IN),
    .FUSE_REF_IN         (FUSE_REF_IN),
    .FUSE_TERM0_IN       (FUSE_TERM0_IN),
    .FUSE_TERM1_IN       (FUSE_TERM1_IN),
    .FUSE_TERM2_IN       (FUSE_TERM2_IN),
    .CORE_SLEEP_OUT      (CORE_SLEEP_OUT),
    .CAL_START_OUT       (CAL_START_OUT),
    .OFFLINE_CORE_OUT    (OFFLINE_CORE_OUT),
    .GAIN_ADJ_OUT        (GAIN_ADJ_OUT),
    .REF_ADJ_OUT         (REF_ADJ_OUT),
    .TERM_ADJ0_OUT       (TERM_ADJ0_OUT),
    .TERM_ADJ1_OUT       (TERM_ADJ1_OUT),
    .TERM_ADJ2_OUT       (TERM_ADJ2_OUT)
  );
  // ==========================================================
  // reporting
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish
  function automatic logic [31:0] in_win(input int got, input longint exp);
    return {31'h0, (got >= exp - 1) && (got <= exp + 3)};
  endfunction : in_win
  // ==========================================================
  // Avalon-MM master: hold until waitrequest is sampled low
  task automatic acc(input bit wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] be = 4'hF);
    int k;
    @(posedge CLK_IN);
    AVS_ADDRESS_IN    <= {idx, 2'b00};
    AVS_WRITEDATA_IN  <= {24'h0, wd};
    AVS_BYTEENABLE_IN <= be;
    AVS_READ_IN       <= !wr;
    AVS_WRITE_IN      <= wr;
    k = 0;
    do begin
      @(posedge CLK_IN);
      k++;
    end while (AVS_WAITREQUEST_OUT !== 1'b0 && k < 50);
    if (k >= 50) chk(32'h1, 32'h0, "bus answer");
    rd = AVS_READDATA_OUT;
    AVS_READ_IN  <= 1'b0;
    AVS_WRITE_IN <= 1'b0;
  endtask : acc
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    acc(0, idx, 8'h00);
    chk(rd, {24'h0, exp}, msg);
  endtask : rdchk
  // sel 0 watches sleep, sel 1 watches calibration start
  task automatic wait_for(input bit sel, input logic lvl, input int lim, output int k);
    k = 0;
    do begin
      @(posedge CLK_IN);
      k++;
    end while (((sel ? CAL_START_OUT : CORE_SLEEP_OUT) !== lvl) && k < lim);
  endtask : wait_for
  task automatic finish_cal;
    core = OFFLINE_CORE_OUT;
    @(posedge CLK_IN) CAL_DONE_IN <= 1'b1;
    @(posedge CLK_IN) CAL_DONE_IN <= 1'b0;
    wait_for(0, 1, 20, n);
    chk(OFFLINE_CORE_OUT, (core == 3'd4) ? 3'd0 : core + 3'd1, "next core");
  endtask : finish_cal
  task automatic stop_seq;
    acc(1, LPC_IDX_CTRL, 8'h88);
    repeat (3) @(posedge CLK_IN);
    chk({CORE_SLEEP_OUT, CAL_START_OUT}, 2'b00, "disabled idle");
  endtask : stop_seq
  // ==========================================================
  initial begin
    CLK_IN = 1'b0;
    forever #2.5 CLK_IN = ~CLK_IN;
  end
  initial begin
    repeat (30000) @(posedge CLK_IN);
    miscompares++;
    tally_and_finish();
  end
  initial begin
    seed = 68;
    void'($urandom(seed));
    {RST_IN, AVS_READ_IN, AVS_WRITE_IN, CAL_DONE_IN, CAL_TRIGGER_PIN_IN} = 5'b10000;
    AVS_ADDRESS_IN = '0;
    AVS_WRITEDATA_IN = '0;
    AVS_BYTEENABLE_IN = 4'hF;
    {FUSE_GAIN_IN, FUSE_TERM0_IN, FUSE_TERM1_IN, FUSE_TERM2_IN} = $urandom;
    FUSE_REF_IN = 4'($urandom);
    miscompares = 0;
    checks = 0;
    repeat (16) @(posedge CLK_IN);
    RST_IN <= 1'b0;
    // reset values of every writable register
    rdchk(LPC_IDX_CTRL, 8'h88, "ctrl reset");
    rdchk(LPC_IDX_SOFT, 8'h01, "soft trigger reset");
    rdchk(LPC_IDX_MODE, 8'h00, "mode reset");
    rdchk(LPC_IDX_GAIN, FUSE_GAIN_IN, "gain fuse");
    rdchk(LPC_IDX_REF, {4'h0, FUSE_REF_IN}, "ref fuse");
    rdchk(LPC_IDX_TERM0, FUSE_TERM0_IN, "term0 fuse");
    rdchk(LPC_IDX_TERM1, FUSE_TERM1_IN, "term1 fuse");
    rdchk(LPC_IDX_TERM2, FUSE_TERM2_IN, "term2 fuse");
    // trims rewritten with random values, outputs follow
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      acc(1, LPC_IDX_GAIN, v);
      rdchk(LPC_IDX_GAIN, v, "gain rw");
      chk(GAIN_ADJ_OUT, v, "gain out");
      acc(1, LPC_IDX_REF, v);
      rdchk(LPC_IDX_REF, v & 8'h0F, "ref rw");
      chk(REF_ADJ_OUT, v[3:0], "ref out");
      acc(1, LPC_IDX_TERM0, v ^ 8'h5A);
      acc(1, LPC_IDX_TERM1, v ^ 8'hA5);
      acc(1, LPC_IDX_TERM2, ~v);
      @(posedge CLK_IN);
      chk({TERM_ADJ0_OUT, TERM_ADJ1_OUT, TERM_ADJ2_OUT}, {v ^ 8'h5A, v ^ 8'hA5, ~v},
          "term out");
      rdchk(LPC_IDX_TERM2, ~v, "term2 rw");
      acc(1, LPC_IDX_CTRL, v & 8'hFE);
      rdchk(LPC_IDX_CTRL, v & 8'hFE & LPC_CTRL_MASK, "ctrl rw");
    end
    // refused accesses leave state alone
    acc(1, LPC_IDX_GAIN, 8'h3C, 4'hE);
    chk(GAIN_ADJ_OUT, v, "lane0 clear write");
    acc(1, 8'h10, 8'hFF);
    rdchk(8'h10, 8'h00, "unmapped read");
    // enable without background mode has no effect
    acc(1, LPC_IDX_CTRL, 8'h89);
    wait_for(0, 1, 60, n);
    chk(CORE_SLEEP_OUT, 1'b0, "enable gated");
    // disable first so the sweep below starts each interval from idle
    acc(1, LPC_IDX_CTRL, 8'h88);
    // autonomous mode, every sleep code and every settle code
    acc(1, LPC_IDX_MODE, 8'h01);
    for (int k = 0; k < 8; k++) begin
      acc(1, LPC_IDX_CTRL, {3'(k), 2'(k % 4), 3'b001});
      wait_for(0, 1, 20, n);
      wait_for(0, 0, 200, d);
      chk(in_win(d, T_SLEEP[k]), 1, "sleep length");
      chk(in_win(d, T_SLEEP[k]), 1, "sleep length long codes");
      wait_for(1, 1, 200, d);
      chk(in_win(d, T_WAKE[k % 4]), 1, "settle length");
      chk(in_win(d, T_WAKE[k % 4]), 1, "settle code table");
      finish_cal();
      chk(CORE_SLEEP_OUT, 1'b1, "autonomous resleep");
      stop_seq();
    end
    // trigger mode with software trigger: sleep field ignored
    acc(1, LPC_IDX_SOFT, 8'h01);
    acc(1, LPC_IDX_CTRL, 8'h0B);
    wait_for(0, 1, 20, n);
    repeat (120) @(posedge CLK_IN);
    chk(CORE_SLEEP_OUT, 1'b1, "held asleep by trigger");
    acc(1, LPC_IDX_SOFT, 8'h00);
    wait_for(0, 0, 20, n);
    chk(n < 8, 1, "wake on trigger low");
    wait_for(1, 1, 200, d);
    chk(in_win(d, T_WAKE[1]), 1, "settle after trigger");
    finish_cal();
    stop_seq();
    // pin as trigger source, software bit low but ignored
    CAL_TRIGGER_PIN_IN <= 1'b1;
    acc(1, LPC_IDX_MODE, 8'h03);
    acc(1, LPC_IDX_CTRL, 8'h0B);
    wait_for(0, 1, 20, n);
    repeat (80) @(posedge CLK_IN);
    chk(CORE_SLEEP_OUT, 1'b1, "pin holds sleep");
    CAL_TRIGGER_PIN_IN <= 1'b0;
    wait_for(0, 0, 20, n);
    chk(n < 10, 1, "pin release wakes");
    stop_seq();
    tally_and_finish();
  end
endmodule : test_lowpower_cal_sleep_wake_and_trims
